// ---- rtl/vic_ctrl.v ----
`timescale 1ns/1ps
`include "vic_map.vh"

module vic_ctrl #(
	parameter N_EXT    = 4,
	parameter EXT_BASE = 13
) (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst_b,
	// register port
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	input  wire [8:0]  i_reg_addr,
	input  wire [31:0] i_reg_wdata,
	output wire [31:0] o_reg_rdata,
	output wire        o_reg_rvalid,
	// interrupt sources
	input  wire [31:0]      i_src,
	input  wire [N_EXT-1:0] i_ext_pin,
	// core side
	input  wire        i_irq_ack,
	input  wire        i_irq_done,
	input  wire        i_fiq_ack,
	input  wire        i_fiq_done,
	output wire        o_irq,
	output wire        o_fiq
);

// -------------------------------------------------------------
// state
// -------------------------------------------------------------
reg  [31:0]      irq_en_ff;
reg  [31:0]      fiq_en_ff;
reg  [31:0]      soft_ff;
reg  [31:0]      base_ff;
reg  [31:0]      prio0_ff;
reg  [31:0]      prio1_ff;
reg  [31:0]      prio2_ff;
reg  [1:0]       nest_ff;
reg  [31:0]      ext_cfg_ff;
reg  [2:0]       irq_lvl_ff;
reg  [2:0]       fiq_lvl_ff;
reg              irq_busy_ff;
reg              fiq_busy_ff;
reg  [31:0]      rdata_ff;
reg              rvalid_ff;
reg  [N_EXT-1:0] sync1_ff;
reg  [N_EXT-1:0] sync2_ff;
reg  [N_EXT-1:0] sync3_ff;
reg  [N_EXT-1:0] filt_ff;
reg  [N_EXT-1:0] filt_d_ff;
reg  [N_EXT-1:0] edge_ff;

wire [31:0]      raw;
wire [31:0]      ext_bits;
wire [95:0]      prio_flat;
wire [31:0]      irq_act;
wire [31:0]      fiq_act;
wire [8:0]       irq_best;
wire [8:0]       fiq_best;
wire [31:0]      irq_vec;
wire [31:0]      fiq_vec;
wire             irq_req;
wire             fiq_req;
reg  [31:0]      nxt_rdata;

wire wr_irq_en  = i_reg_wr & (i_reg_addr == `VIC_OFS_IRQ_ENABLE);
wire wr_irq_dis = i_reg_wr & (i_reg_addr == `VIC_OFS_IRQ_DISABLE);
wire wr_fiq_en  = i_reg_wr & (i_reg_addr == `VIC_OFS_FIQ_ENABLE);
wire wr_fiq_dis = i_reg_wr & (i_reg_addr == `VIC_OFS_FIQ_DISABLE);
wire wr_soft    = i_reg_wr & (i_reg_addr == `VIC_OFS_SOFT_TRIG);
wire wr_base    = i_reg_wr & (i_reg_addr == `VIC_OFS_VEC_BASE);
wire wr_p0      = i_reg_wr & (i_reg_addr == `VIC_OFS_PRIO0);
wire wr_p1      = i_reg_wr & (i_reg_addr == `VIC_OFS_PRIO1);
wire wr_p2      = i_reg_wr & (i_reg_addr == `VIC_OFS_PRIO2);
wire wr_nest    = i_reg_wr & (i_reg_addr == `VIC_OFS_NEST_CTRL);
wire wr_ecfg    = i_reg_wr & (i_reg_addr == `VIC_OFS_EXT_CFG);
wire wr_eclr    = i_reg_wr & (i_reg_addr == `VIC_OFS_EXT_CLR);
wire wr_ilvl    = i_reg_wr & (i_reg_addr == `VIC_OFS_IRQ_LEVEL);
wire wr_flvl    = i_reg_wr & (i_reg_addr == `VIC_OFS_FIQ_LEVEL);

// -------------------------------------------------------------
// best source search: lowest priority number wins,
// ties go to the lowest source number
// returns {found, prio[2:0], index[4:0]}
// -------------------------------------------------------------
function [8:0] vic_pick;
	input [31:0] act;
	input [95:0] prio;
	integer      k;
	reg          found;
	reg   [2:0]  bp;
	reg   [4:0]  bi;
	begin
		found = 1'b0;
		bp    = 3'h7;
		bi    = 5'h00;
		for (k = 0; k < 32; k = k + 1)
		begin
			if (act[k] && (!found || prio[3*k +: 3] < bp))
			begin
				found = 1'b1;
				bp    = prio[3*k +: 3];
				bi    = k[4:0];
			end
		end
		vic_pick = {found, bp, bi};
	end
endfunction

// -------------------------------------------------------------
// external pin synchroniser and edge latch
// -------------------------------------------------------------
// three stages; a change counts once stages two and three agree
always @(posedge i_clk)
begin
	if (!i_rst_b)
	begin
		sync1_ff  <= {N_EXT{1'b0}};
		sync2_ff  <= {N_EXT{1'b0}};
		sync3_ff  <= {N_EXT{1'b0}};
		filt_ff   <= {N_EXT{1'b0}};
		filt_d_ff <= {N_EXT{1'b0}};
	end
	else
	begin
		sync1_ff  <= i_ext_pin;
		sync2_ff  <= sync1_ff;
		sync3_ff  <= sync2_ff;
		filt_ff   <= (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));
		filt_d_ff <= filt_ff;
	end
end

genvar e;
generate
	for (e = 0; e < N_EXT; e = e + 1)
	begin : g_ext
		wire [1:0] mode = ext_cfg_ff[`VIC_EXT_FLD_W*e +: `VIC_EXT_FLD_W];
		wire rise = filt_ff[e] & ~filt_d_ff[e];
		wire fall = ~filt_ff[e] & filt_d_ff[e];
		wire hit  = (mode == `VIC_TRIG_RISE) ? rise :
			    (mode == `VIC_TRIG_FALL) ? fall : 1'b0;
		wire clr  = wr_eclr & i_reg_wdata[EXT_BASE + e];
		// set wins over a clear in the same cycle
		always @(posedge i_clk)
		begin
			if (!i_rst_b)
				edge_ff[e] <= 1'b0;
			else
				edge_ff[e] <= (edge_ff[e] & ~clr) | hit;
		end
		assign ext_bits[EXT_BASE + e] =
			(mode == `VIC_TRIG_LVL_HI) ? filt_ff[e] :
			(mode == `VIC_TRIG_LVL_LO) ? ~filt_ff[e] :
			edge_ff[e];
	end
endgenerate

// non-external bits carry no pin term
genvar z;
generate
	for (z = 0; z < 32; z = z + 1)
	begin : g_noext
		if (z < EXT_BASE || z >= EXT_BASE + N_EXT)
		begin : g_zero
			assign ext_bits[z] = 1'b0;
		end
	end
endgenerate

// -------------------------------------------------------------
// source levels and per-source priority
// -------------------------------------------------------------
// raw level of every source, enabled or not
assign raw = i_src | soft_ff | ext_bits;

genvar n;
generate
	for (n = 0; n < 32; n = n + 1)
	begin : g_prio
		if (n < 8)
		begin : g_p0
			assign prio_flat[3*n +: 3] =
				prio0_ff[`VIC_PRIO_FLD_W*n +: 3];
		end
		else if (n < 16)
		begin : g_p1
			assign prio_flat[3*n +: 3] =
				prio1_ff[`VIC_PRIO_FLD_W*(n-8) +: 3];
		end
		else if (n <= `VIC_PRIO_LAST)
		begin : g_p2
			assign prio_flat[3*n +: 3] =
				prio2_ff[`VIC_PRIO_FLD_W*(n-16) +: 3];
		end
		else
		begin : g_pnone
			assign prio_flat[3*n +: 3] = 3'h0;
		end
	end
endgenerate

// active sources and winners
assign irq_act  = raw & irq_en_ff;
assign fiq_act  = raw & fiq_en_ff;
assign irq_best = vic_pick(irq_act, prio_flat);
assign fiq_best = vic_pick(fiq_act, prio_flat);
assign irq_vec  = base_ff + {25'h0000000, irq_best[4:0], 2'h0};
assign fiq_vec  = base_ff + {25'h0000000, fiq_best[4:0], 2'h0};

// -------------------------------------------------------------
// core request lines
// -------------------------------------------------------------
// while in service, only a strictly lower level number preempts, and only with the nest bit set
assign fiq_req = fiq_best[8] & (!fiq_busy_ff ||
	(nest_ff[`VIC_NEST_FIQ_BIT] && fiq_best[7:5] < fiq_lvl_ff));
assign irq_req = irq_best[8] & (!irq_busy_ff ||
	(nest_ff[`VIC_NEST_IRQ_BIT] && irq_best[7:5] < irq_lvl_ff));
assign o_fiq   = fiq_req;
assign o_irq   = irq_req & ~fiq_req;

// -------------------------------------------------------------
// software-visible control registers
// -------------------------------------------------------------
always @(posedge i_clk)
begin
	if (!i_rst_b)
	begin
		irq_en_ff  <= `VIC_RST_WORD;
		fiq_en_ff  <= `VIC_RST_WORD;
		soft_ff    <= `VIC_RST_WORD;
		base_ff    <= `VIC_RST_WORD;
		prio0_ff   <= `VIC_RST_WORD;
		prio1_ff   <= `VIC_RST_WORD;
		prio2_ff   <= `VIC_RST_WORD;
		nest_ff    <= 2'h0;
		ext_cfg_ff <= `VIC_RST_WORD;
	end
	else
	begin
		// enable bits: ones set, disable ones clear
		if (wr_irq_en)
			irq_en_ff <= irq_en_ff | i_reg_wdata;
		else if (wr_irq_dis)
			irq_en_ff <= irq_en_ff & ~i_reg_wdata;
		if (wr_fiq_en)
			fiq_en_ff <= fiq_en_ff | i_reg_wdata;
		else if (wr_fiq_dis)
			fiq_en_ff <= fiq_en_ff & ~i_reg_wdata;
		if (wr_soft)
			soft_ff <= i_reg_wdata;
		if (wr_base)
			base_ff <= i_reg_wdata;
		if (wr_p0)
			prio0_ff <= i_reg_wdata & `VIC_PRIO_MASK0;
		if (wr_p1)
			prio1_ff <= i_reg_wdata & `VIC_PRIO_MASK1;
		if (wr_p2)
			prio2_ff <= i_reg_wdata & `VIC_PRIO_MASK2;
		if (wr_nest)
			nest_ff <= i_reg_wdata[1:0];
		if (wr_ecfg)
			ext_cfg_ff <= i_reg_wdata;
	end
end

// -------------------------------------------------------------
// service level tracking
// -------------------------------------------------------------
// entry records the winning level; exit ends service
always @(posedge i_clk)
begin
	if (!i_rst_b)
	begin
		irq_lvl_ff  <= `VIC_RST_LEVEL;
		fiq_lvl_ff  <= `VIC_RST_LEVEL;
		irq_busy_ff <= 1'b0;
		fiq_busy_ff <= 1'b0;
	end
	else
	begin
		// level: ack wins over a software write
		if (i_irq_ack)
			irq_lvl_ff <= irq_best[7:5];
		else if (wr_ilvl)
			irq_lvl_ff <= i_reg_wdata[2:0];
		// busy apart, so a level write cannot swallow a done pulse
		if (i_irq_ack)
			irq_busy_ff <= 1'b1;
		else if (i_irq_done)
			irq_busy_ff <= 1'b0;
		// fast side keeps the same bookkeeping
		if (i_fiq_ack)
			fiq_lvl_ff <= fiq_best[7:5];
		else if (wr_flvl)
			fiq_lvl_ff <= i_reg_wdata[2:0];
		if (i_fiq_ack)
			fiq_busy_ff <= 1'b1;
		else if (i_fiq_done)
			fiq_busy_ff <= 1'b0;
	end
end

// -------------------------------------------------------------
// read mux
// -------------------------------------------------------------
always @*
begin
	case (i_reg_addr)
	`VIC_OFS_IRQ_ACTIVE: nxt_rdata = irq_act;
	`VIC_OFS_IRQ_RAW:    nxt_rdata = raw;
	`VIC_OFS_IRQ_ENABLE: nxt_rdata = irq_en_ff;
	`VIC_OFS_VEC_BASE:   nxt_rdata = base_ff;
	`VIC_OFS_IRQ_VECTOR: nxt_rdata = irq_best[8] ? irq_vec : 32'h00000000;
	`VIC_OFS_PRIO0:      nxt_rdata = prio0_ff;
	`VIC_OFS_PRIO1:      nxt_rdata = prio1_ff;
	`VIC_OFS_PRIO2:      nxt_rdata = prio2_ff;
	`VIC_OFS_NEST_CTRL:  nxt_rdata = {30'h00000000, nest_ff};
	`VIC_OFS_EXT_CFG:    nxt_rdata = ext_cfg_ff;
	`VIC_OFS_IRQ_LEVEL:  nxt_rdata = {29'h00000000, irq_lvl_ff};
	`VIC_OFS_FIQ_ACTIVE: nxt_rdata = fiq_act;
	`VIC_OFS_FIQ_RAW:    nxt_rdata = raw;
	`VIC_OFS_FIQ_ENABLE: nxt_rdata = fiq_en_ff;
	`VIC_OFS_FIQ_VECTOR: nxt_rdata = fiq_best[8] ? fiq_vec : 32'h00000000;
	`VIC_OFS_FIQ_LEVEL:  nxt_rdata = {29'h00000000, fiq_lvl_ff};
	default:             nxt_rdata = 32'h00000000;
	endcase
end

// read data registered, valid one cycle after the strobe
always @(posedge i_clk)
begin
	if (!i_rst_b)
	begin
		rdata_ff  <= 32'h00000000;
		rvalid_ff <= 1'b0;
	end
	else
	begin
		rvalid_ff <= i_reg_rd;
		if (i_reg_rd)
			rdata_ff <= nxt_rdata;
	end
end

assign o_reg_rdata  = rdata_ff;
assign o_reg_rvalid = rvalid_ff;

endmodule // vic_ctrl

// ---- common/vic_map.vh ----
`ifndef VIC_MAP_VH
`define VIC_MAP_VH

// -------------------------------------------------------------
// register offsets (byte addresses)
// -------------------------------------------------------------
`define VIC_OFS_IRQ_ACTIVE     9'h000
`define VIC_OFS_IRQ_RAW        9'h004
`define VIC_OFS_IRQ_ENABLE     9'h008
`define VIC_OFS_IRQ_DISABLE    9'h00C
`define VIC_OFS_SOFT_TRIG      9'h010
`define VIC_OFS_VEC_BASE       9'h014
`define VIC_OFS_IRQ_VECTOR     9'h01C
`define VIC_OFS_PRIO0          9'h020
`define VIC_OFS_PRIO1          9'h024
`define VIC_OFS_PRIO2          9'h028
`define VIC_OFS_RESERVED       9'h02C
`define VIC_OFS_NEST_CTRL      9'h030
`define VIC_OFS_EXT_CFG        9'h034
`define VIC_OFS_EXT_CLR        9'h038
`define VIC_OFS_IRQ_LEVEL      9'h03C
`define VIC_OFS_FIQ_ACTIVE     9'h100
`define VIC_OFS_FIQ_RAW        9'h104
`define VIC_OFS_FIQ_ENABLE     9'h108
`define VIC_OFS_FIQ_DISABLE    9'h10C
`define VIC_OFS_FIQ_VECTOR     9'h11C
`define VIC_OFS_FIQ_LEVEL      9'h13C

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define VIC_RST_WORD           32'h00000000
`define VIC_RST_LEVEL          3'h0

// -------------------------------------------------------------
// field positions and masks
// -------------------------------------------------------------
`define VIC_PRIO_MASK0         32'h77777770
`define VIC_PRIO_MASK1         32'h77777777
`define VIC_PRIO_MASK2         32'h00777777
`define VIC_PRIO_FIRST         1
`define VIC_PRIO_LAST          21
`define VIC_PRIO_FLD_W         4
`define VIC_NEST_IRQ_BIT       0
`define VIC_NEST_FIQ_BIT       1
`define VIC_EXT_FLD_W          2
`define VIC_VEC_SHIFT          2

// -------------------------------------------------------------
// external trigger modes
// -------------------------------------------------------------
`define VIC_TRIG_RISE          2'h0
`define VIC_TRIG_FALL          2'h1
`define VIC_TRIG_LVL_HI        2'h2
`define VIC_TRIG_LVL_LO        2'h3

`endif

// ---- test/vic_ctrl_asserts.sv ----
`timescale 1ns/1ps
module vic_ctrl_asserts (
	// watched ports
	input wire        i_clk,
	input wire        i_rst_b,
	input wire        i_reg_wr,
	input wire        i_reg_rd,
	input wire [8:0]  i_reg_addr,
	input wire [31:0] i_reg_wdata,
	input wire [31:0] o_reg_rdata,
	input wire        o_reg_rvalid,
	input wire        o_irq,
	input wire        o_fiq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// reads of places that hold nothing readable
	wire dead_rd = i_reg_rd && (i_reg_addr == 9'h00C ||
		i_reg_addr == 9'h10C || i_reg_addr == 9'h010 ||
		i_reg_addr == 9'h02C || i_reg_addr == 9'h038 ||
		i_reg_addr == 9'h0F0);
	// ---------------------------------------------
	// register port
	// ---------------------------------------------
	property p_rd_ans;
		i_reg_rd |=> o_reg_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read not answered next cycle");
	property p_no_rd;
		!i_reg_rd |=> !o_reg_rvalid;
	endproperty
	a_no_rd: assert property (p_no_rd)
		else $error("answer without read");
	property p_hold;
		!o_reg_rvalid |-> $stable(o_reg_rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without answer");
	property p_dead;
		dead_rd |=> o_reg_rdata == 32'h00000000;
	endproperty
	a_dead: assert property (p_dead)
		else $error("unreadable place gave data");
	// ---------------------------------------------
	// request lines
	// ---------------------------------------------
	property p_irq_off;
		i_reg_wr && i_reg_addr == 9'h00C &&
		i_reg_wdata == 32'hFFFFFFFF |=> !o_irq;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("irq after all sources disabled");
	property p_fiq_off;
		i_reg_wr && i_reg_addr == 9'h10C &&
		i_reg_wdata == 32'hFFFFFFFF |=> !o_fiq;
	endproperty
	a_fiq_off: assert property (p_fiq_off)
		else $error("fiq after all sources disabled");
	property p_fiq_first;
		o_fiq |-> !o_irq;
	endproperty
	a_fiq_first: assert property (p_fiq_first)
		else $error("irq raised beside fiq");
	property p_rst_out;
		$rose(i_rst_b) |-> !o_irq && !o_fiq && !o_reg_rvalid;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs busy after reset");
endmodule // vic_ctrl_asserts

// ---- test/vic_core_model.sv ----
`timescale 1ns/1ps
module vic_core_model #(
	parameter DLY = 6
) (
	input  wire       i_clk,
	input  wire       i_rst_b,
	input  wire       i_en,
	input  wire       i_irq,
	input  wire       i_fiq,
	output reg        o_irq_ack,
	output reg        o_irq_done,
	output reg        o_fiq_ack,
	output reg        o_fiq_done
);
	reg [3:0] cnt_ff;
	reg       busy_ff;
	reg       fast_ff;
	// take one exception, run handler, then report done
	always @(posedge i_clk)
	begin
		{o_irq_ack, o_fiq_ack, o_irq_done, o_fiq_done} <= 4'h0;
		if (!i_rst_b)
			busy_ff <= 1'b0;
		else if (busy_ff)
		begin
			cnt_ff <= cnt_ff - 4'h1;
			if (cnt_ff == 4'h0)
			begin
				busy_ff    <= 1'b0;
				o_irq_done <= !fast_ff;
				o_fiq_done <= fast_ff;
			end
		end
		else if (i_en && (i_fiq || i_irq))
		begin
			busy_ff   <= 1'b1;
			fast_ff   <= i_fiq;
			cnt_ff    <= DLY[3:0];
			o_fiq_ack <= i_fiq;
			o_irq_ack <= !i_fiq;
		end
	end
endmodule // vic_core_model

// ---- test/vectored_irq_fiq_controller_tb_top.sv ----
`timescale 1ns/1ps
module vectored_irq_fiq_controller_tb_top;
	reg         i_clk = 0, i_rst_b = 0, i_reg_wr = 0, i_reg_rd = 0, cen = 0;
	reg  [8:0]  i_reg_addr = 9'h000;
	reg  [31:0] i_reg_wdata = 32'h0, i_src = 32'h0, s, e, d, f, b;
	reg  [3:0]  i_ext_pin = 4'h0;
	wire [31:0] o_reg_rdata;
	wire        o_reg_rvalid, o_irq, o_fiq, ia, id, fa, fd;
	integer     error_cnt = 0, check_count = 0, k;
	// word offsets of sixteen register places, all zero after reset
	localparam [127:0] RST = 128'h00020507_08090A0B_0C0D0E0F_40424F47;
	always #2.5 i_clk = ~i_clk;
	vic_ctrl #(.N_EXT(4), .EXT_BASE(13)) vic_ctrl_inst (.i_clk(i_clk),
		.i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.i_src(i_src), .i_ext_pin(i_ext_pin), .i_irq_ack(ia),
		.i_irq_done(id), .i_fiq_ack(fa), .i_fiq_done(fd),
		.o_irq(o_irq), .o_fiq(o_fiq));
	vic_core_model #(.DLY(12)) vic_core_model_inst (.i_clk(i_clk),
		.i_rst_b(i_rst_b), .i_en(cen), .i_irq(o_irq), .i_fiq(o_fiq),
		.o_irq_ack(ia), .o_irq_done(id), .o_fiq_ack(fa),
		.o_fiq_done(fd));
	// ---------------------------------------------
	// compare and bus tasks
	// ---------------------------------------------
	task chk(input [63:0] nm, input [31:0] x, input [31:0] g);
	begin
		check_count = check_count + 1;
		if (g !== x)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0s exp %h got %h", nm, x, g);
		end
	end
	endtask
	task chl(input [63:0] nm, input x, input g);
	begin
		check_count = check_count + 1;
		if (g !== x)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0s exp %b got %b", nm, x, g);
		end
	end
	endtask
	task wr(input [8:0] a, input [31:0] v);
	begin
		@(posedge i_clk);
		i_reg_wr    <= 1'b1;
		i_reg_addr  <= a;
		i_reg_wdata <= v;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	end
	endtask
	task rd(input [8:0] a, input [31:0] x);
	begin
		@(posedge i_clk);
		i_reg_rd   <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		// read data stands from the answer edge until the next read
		@(posedge i_clk);
		chk("rdata", x, o_reg_rdata);
	end
	endtask
	task wt(input integer n);
	begin
		repeat (n) @(posedge i_clk);
	end
	endtask
	task complete_run;
	begin
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	initial
	begin
		k = $urandom(32'h4eb3);
		wt(16);
		i_rst_b <= 1'b1;
		for (k = 0; k < 16; k = k + 1)
			rd({RST[8*k +: 8], 1'b0} << 1, 32'h0);
		rd(9'h0F0, 32'h0);
		repeat (4)
		begin
			s = $urandom & 32'h00001FFF;
			e = $urandom;
			d = $urandom;
			f = $urandom & 32'h00001FFF;
			i_src <= s;
			wr(9'h008, e);
			rd(9'h004, s);
			rd(9'h104, s);
			rd(9'h000, s & e);
			chl("irq", |(s & e), o_irq);
			wr(9'h008, 32'h0);
			rd(9'h008, e);
			wr(9'h00C, d);
			rd(9'h008, e & ~d);
			wr(9'h108, f);
			rd(9'h100, s & f);
			chl("fiq", |(s & f), o_fiq);
			chl("irq", !(|(s & f)) && |(s & e & ~d), o_irq);
			wr(9'h10C, d);
			rd(9'h108, f & ~d);
			wr(9'h10C, 32'hFFFFFFFF);
			wr(9'h00C, 32'hFFFFFFFF);
		end
		i_src <= 32'h0;
		s = $urandom & 32'h00001FFF;
		wr(9'h010, s);
		rd(9'h004, s);
		wr(9'h010, 32'h0);
		b = $urandom;
		k = $urandom % 13;
		wr(9'h014, b);
		rd(9'h014, b);
		i_src <= 32'h1 << k;
		wr(9'h008, 32'h1 << k);
		rd(9'h01C, b + 4 * k);
		wr(9'h00C, 32'hFFFFFFFF);
		i_src <= 32'h208;
		wr(9'h008, 32'h208);
		wr(9'h020, 32'hFFFF5000);
		wr(9'h024, 32'h20);
		rd(9'h020, 32'h77775000);
		rd(9'h01C, b + 36);
		cen <= 1'b1;
		wt(3);
		cen <= 1'b0;
		wt(12);
		rd(9'h03C, 32'h2);
		wr(9'h108, 32'h8);
		cen <= 1'b1;
		wt(3);
		cen <= 1'b0;
		wt(12);
		rd(9'h13C, 32'h5);
		wr(9'h10C, 32'hFFFFFFFF);
		wr(9'h00C, 32'hFFFFFFFF);
		// irq in service at level 5, then a level 2 source arrives
		wr(9'h008, 32'h8);
		cen <= 1'b1;
		wt(3);
		cen <= 1'b0;
		chl("irq", 1'b0, o_irq);
		wr(9'h008, 32'h200);
		wt(1);
		chl("irq", 1'b0, o_irq);
		wr(9'h030, 32'h1);
		wt(1);
		chl("irq", 1'b1, o_irq);
		rd(9'h030, 32'h1);
		wt(8);
		wr(9'h00C, 32'hFFFFFFFF);
		i_src <= 32'h0;
		wr(9'h008, 32'h2000);
		for (k = 0; k < 4; k = k + 1)
		begin
			wr(9'h034, k);
			wr(9'h038, 32'h2000);
			i_ext_pin <= 4'h1;
			wt(8);
			i_ext_pin <= 4'h0;
			wt(8);
			rd(9'h000, (k == 2) ? 32'h0 : 32'h2000);
		end
		wr(9'h034, 32'h0);
		i_ext_pin <= 4'h1;
		wt(8);
		rd(9'h000, 32'h2000);
		wr(9'h038, 32'h2000);
		rd(9'h000, 32'h0);
		complete_run;
	end
	// watchdog against a hung run
	initial
	begin
		#50000;
		error_cnt = error_cnt + 1;
		complete_run;
	end
endmodule // vectored_irq_fiq_controller_tb_top
bind vic_ctrl vic_ctrl_asserts vic_ctrl_asserts_inst (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
	.o_irq(o_irq), .o_fiq(o_fiq));
